// File: common/dotmr_pkg.sv
// dual-output up/down pwm timer: shared constants, modes and carrier structs
// assumes one 25 MHz reference clock and no register bus; all settings are ports

package dotmr_pkg;

  localparam int CNT_W = 16;
  localparam int PRE_W = 12;
  localparam int DLY_W = 10;
  localparam int GROUP_N = 4;
  localparam int FLAG_N = 6;

  // flag bit positions
  localparam int FLAG_A = 0;
  localparam int FLAG_B = 1;
  localparam int FLAG_PERIOD = 2;
  localparam int FLAG_BOTTOM = 3;
  localparam int FLAG_CAPTURE = 4;
  localparam int FLAG_FORCE = 5;

  // reset values
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [PRE_W-1:0] PRE_RST = 12'h000;
  localparam logic [DLY_W-1:0] DLY_RST = 10'h000;
  localparam logic [FLAG_N-1:0] FLAGS_RST = 6'h00;

  typedef enum logic [1:0] {
    MODE_INTERVAL = 2'h0,
    MODE_CAPTURE = 2'h1,
    MODE_ONESHOT = 2'h3,
    MODE_B2B = 2'h2
  } dotmr_mode_e;

  typedef enum logic [1:0] {
    UPD_WRITE = 2'h0,
    UPD_PERIOD = 2'h1,
    UPD_BOTTOM = 2'h2,
    UPD_RSVD = 2'h3
  } dotmr_upd_e;

  // input valid level / capture edge encodings
  localparam logic [1:0] INP_LOW_FALL = 2'h0;
  localparam logic [1:0] INP_HIGH_RISE = 2'h1;
  localparam logic [1:0] INP_BOTH = 2'h2;

  typedef struct packed {
    logic clock_source_select;
    dotmr_mode_e operating_mode_field;
    logic [PRE_W-1:0] prescaler_value;
    logic [CNT_W-1:0] period_value;
    logic [CNT_W-1:0] duty_a_value;
    logic [CNT_W-1:0] duty_b_value;
    logic start_level_a;
    logic start_level_b;
    logic output_a_enable;
    logic output_b_enable;
    logic inactive_level_a;
    logic inactive_level_b;
    dotmr_upd_e reload_timing_field;
    logic delay_insert_enable;
    logic delay_position_select;
    logic [DLY_W-1:0] output_delay_value;
    logic force_enable;
    logic [1:0] force_source_select;
    logic [1:0] input_valid_level;
    logic counter_share_enable;
    logic [1:0] share_master_select;
  } dotmr_cfg_s;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic down;
    logic tick;
    logic pm;
    logic bot;
  } dotmr_share_s;

  typedef struct packed {
    logic ext_clk;
    logic [GROUP_N-1:0] inp;
  } dotmr_pins_s;

endpackage

// File: hdl/dotmr_sync.sv
// two-flop synchroniser for the external clock and capture/force pins
// assumes pins are asynchronous to i_ref_clk
`timescale 1ns/1ps

module dotmr_sync (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // pins in, synchronised copy out
  input wire dotmr_pkg::dotmr_pins_s i_pins,
  output dotmr_pkg::dotmr_pins_s o_pins
);

  typedef struct packed {
    dotmr_pkg::dotmr_pins_s meta;
    dotmr_pkg::dotmr_pins_s sync;
  } dotmr_sync_s;

  dotmr_sync_s st_reg;
  dotmr_sync_s st_next;

  always_comb
  begin
    st_next.meta = i_pins;
    st_next.sync = st_reg.meta;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // only the second stage leaves this module
  assign o_pins = st_reg.sync;

endmodule // dotmr_sync

// File: hdl/dotmr_timer.sv
// dual-output up/down pwm timer with prescaler, capture, force and counter sharing
// assumes settings are quasi-static ports; flags clear by a one-cycle write-one vector;
// sharing neighbours sit on the same clock and exchange o_share through i_share_group
`timescale 1ns/1ps

module dotmr_timer (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // software settings and commands
  input wire dotmr_pkg::dotmr_cfg_s i_cfg,
  input wire logic i_timer_enable_bit,
  input wire logic i_counter_clear_bit,
  input wire logic [dotmr_pkg::FLAG_N-1:0] i_flag_clear,
  // pins
  input wire logic i_external_count_clock,
  input wire logic [dotmr_pkg::GROUP_N-1:0] i_capture_force_input,
  // counter sharing group
  input wire dotmr_pkg::dotmr_share_s [dotmr_pkg::GROUP_N-1:0] i_share_group,
  output dotmr_pkg::dotmr_share_s o_share,
  // status
  output logic o_timer_enable_bit,
  output logic [dotmr_pkg::CNT_W-1:0] o_counter,
  output logic [dotmr_pkg::CNT_W-1:0] o_captured_count,
  output logic [dotmr_pkg::FLAG_N-1:0] o_flags,
  // pwm pins
  output logic o_pwm_output_a,
  output logic o_pwm_output_b
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic en_prev;
    logic run;
    logic [dotmr_pkg::PRE_W-1:0] presc;
    dotmr_pkg::dotmr_share_s own;
    logic [dotmr_pkg::CNT_W-1:0] buf_period;
    logic [dotmr_pkg::CNT_W-1:0] buf_a;
    logic [dotmr_pkg::CNT_W-1:0] buf_b;
    logic [dotmr_pkg::CNT_W-1:0] cap;
    logic [dotmr_pkg::FLAG_N-1:0] flags;
    logic ext_prev;
    logic inp_prev;
    logic lvl_a;
    logic lvl_b;
    logic [dotmr_pkg::DLY_W-1:0] dcnt_a;
    logic [dotmr_pkg::DLY_W-1:0] dcnt_b;
    logic forced;
    logic pin_a;
    logic pin_b;
  } dotmr_state_s;

  dotmr_state_s st_reg;
  dotmr_state_s st_next;
  dotmr_pkg::dotmr_pins_s pins_q;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // compare level: start level while counter is below duty
  function automatic logic pwm_level(
    input logic [dotmr_pkg::CNT_W-1:0] cnt,
    input logic [dotmr_pkg::CNT_W-1:0] duty,
    input logic start
  );
    pwm_level = (cnt < duty) ? start : ~start;
  endfunction

  // one delay stage; returns {level, count}; selected edge waits dly+1 ticks
  function automatic logic [dotmr_pkg::DLY_W:0] delay_step(
    input logic raw,
    input logic cur,
    input logic [dotmr_pkg::DLY_W-1:0] dcnt,
    input logic hold_edge,
    input logic tick,
    input logic [dotmr_pkg::DLY_W-1:0] dly
  );
    logic lvl;
    logic [dotmr_pkg::DLY_W-1:0] c;
    lvl = cur;
    c = dcnt;
    if (raw == cur)
    begin
      c = dotmr_pkg::DLY_RST;
    end
    else if (!hold_edge)
    begin
      lvl = raw;
      c = dotmr_pkg::DLY_RST;
    end
    else if (tick)
    begin
      if (dcnt == dly)
      begin
        lvl = raw;
        c = dotmr_pkg::DLY_RST;
      end
      else
      begin
        c = dcnt + 10'h001;
      end
    end
    delay_step = {lvl, c};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser

  dotmr_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_pins({i_external_count_clock, i_capture_force_input}),
    .o_pins(pins_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic presc_tick;
    logic tick;
    logic clear;
    logic inp;
    logic inp_valid;
    logic cap_edge;
    logic upd;
    logic raw_a;
    logic raw_b;
    logic lead_a;
    logic lead_b;
    logic [dotmr_pkg::DLY_W:0] da;
    logic [dotmr_pkg::DLY_W:0] db;
    logic [dotmr_pkg::FLAG_N-1:0] ev;
    dotmr_pkg::dotmr_share_s eff;

    presc_tick = 1'b0;
    tick = 1'b0;
    clear = i_counter_clear_bit | ~st_reg.run;
    inp = 1'b0;
    inp_valid = 1'b0;
    cap_edge = 1'b0;
    upd = 1'b0;
    ev = '0;
    raw_a = 1'b0;
    raw_b = 1'b0;
    lead_a = 1'b0;
    lead_b = 1'b0;
    da = '0;
    db = '0;
    eff = '0;
    st_next = st_reg;

    // enable: rising edge starts, low stops; hardware may clear it in one-shot
    st_next.en_prev = i_timer_enable_bit;
    if (!i_timer_enable_bit)
    begin
      st_next.run = 1'b0;
    end
    else if (!st_reg.en_prev)
    begin
      st_next.run = 1'b1;
    end

    // count clock source
    st_next.ext_prev = pins_q.ext_clk;
    if (clear)
    begin
      st_next.presc = dotmr_pkg::PRE_RST;
    end
    else if (st_reg.presc == i_cfg.prescaler_value)
    begin
      st_next.presc = dotmr_pkg::PRE_RST;
      presc_tick = 1'b1;
    end
    else
    begin
      st_next.presc = st_reg.presc + 12'h001;
    end
    tick = st_reg.run & (i_cfg.clock_source_select ?
      (pins_q.ext_clk & ~st_reg.ext_prev) : presc_tick);

    // own counter; event bits are registered alongside the new count
    st_next.own.tick = 1'b0;
    st_next.own.pm = 1'b0;
    st_next.own.bot = 1'b0;
    if (clear)
    begin
      st_next.own.cnt = dotmr_pkg::CNT_RST;
      st_next.own.down = 1'b0;
    end
    else if (tick)
    begin
      st_next.own.tick = 1'b1;
      unique case (i_cfg.operating_mode_field)
        dotmr_pkg::MODE_B2B:
        begin
          if (!st_reg.own.down)
          begin
            if (st_reg.own.cnt == st_reg.buf_period)
            begin
              st_next.own.pm = 1'b1;
              st_next.own.down = 1'b1;
              st_next.own.cnt = st_reg.own.cnt - 16'h0001;
            end
            else
            begin
              st_next.own.cnt = st_reg.own.cnt + 16'h0001;
            end
          end
          else if (st_reg.own.cnt == 16'h0000)
          begin
            st_next.own.bot = 1'b1;
            st_next.own.down = 1'b0;
            st_next.own.cnt = 16'h0001;
          end
          else
          begin
            st_next.own.cnt = st_reg.own.cnt - 16'h0001;
          end
        end
        dotmr_pkg::MODE_INTERVAL,
        dotmr_pkg::MODE_CAPTURE,
        dotmr_pkg::MODE_ONESHOT:
        begin
          if (st_reg.own.cnt == st_reg.buf_period)
          begin
            st_next.own.pm = 1'b1;
            st_next.own.cnt = dotmr_pkg::CNT_RST;
            if (i_cfg.operating_mode_field == dotmr_pkg::MODE_ONESHOT)
            begin
              st_next.run = 1'b0;
            end
          end
          else
          begin
            st_next.own.cnt = st_reg.own.cnt + 16'h0001;
          end
        end
      endcase
    end

    // slaves run on the chosen master's registered counter and events
    eff = i_cfg.counter_share_enable ?
      i_share_group[i_cfg.share_master_select] : st_reg.own;

    // buffered period and duties
    unique case (i_cfg.reload_timing_field)
      dotmr_pkg::UPD_WRITE: upd = 1'b1;
      dotmr_pkg::UPD_PERIOD: upd = eff.pm;
      dotmr_pkg::UPD_BOTTOM: upd = eff.bot |
        (eff.pm & (i_cfg.operating_mode_field != dotmr_pkg::MODE_B2B));
      dotmr_pkg::UPD_RSVD: upd = 1'b0;
    endcase
    if (upd | ~st_reg.run)
    begin
      st_next.buf_period = i_cfg.period_value;
      st_next.buf_a = i_cfg.duty_a_value;
      st_next.buf_b = i_cfg.duty_b_value;
    end

    // match events follow the tick that produced the count
    ev[dotmr_pkg::FLAG_A] = st_reg.run & eff.tick & (eff.cnt == st_reg.buf_a);
    ev[dotmr_pkg::FLAG_B] = st_reg.run & eff.tick & (eff.cnt == st_reg.buf_b);
    ev[dotmr_pkg::FLAG_PERIOD] = eff.pm;
    ev[dotmr_pkg::FLAG_BOTTOM] = eff.bot;

    // capture and force input
    inp = pins_q.inp[i_cfg.force_source_select];
    st_next.inp_prev = inp;
    unique case (i_cfg.input_valid_level)
      dotmr_pkg::INP_LOW_FALL:
      begin
        inp_valid = ~inp;
        cap_edge = st_reg.inp_prev & ~inp;
      end
      dotmr_pkg::INP_HIGH_RISE:
      begin
        inp_valid = inp;
        cap_edge = ~st_reg.inp_prev & inp;
      end
      dotmr_pkg::INP_BOTH:
      begin
        inp_valid = 1'b0;
        cap_edge = st_reg.inp_prev ^ inp;
      end
      default:
      begin
        inp_valid = 1'b0;
        cap_edge = 1'b0;
      end
    endcase
    if (st_reg.run && cap_edge &&
        i_cfg.operating_mode_field == dotmr_pkg::MODE_CAPTURE)
    begin
      st_next.cap = eff.cnt;
      ev[dotmr_pkg::FLAG_CAPTURE] = 1'b1;
    end

    // force holds the outputs inactive until the period after the input clears
    if (!i_cfg.force_enable)
    begin
      st_next.forced = 1'b0;
    end
    else if (inp_valid)
    begin
      st_next.forced = 1'b1;
      ev[dotmr_pkg::FLAG_FORCE] = ~st_reg.forced;
    end
    else if (eff.pm)
    begin
      st_next.forced = 1'b0;
    end

    // sticky flags; a new event beats a clear in the same cycle
    st_next.flags = (st_reg.flags & ~i_flag_clear) | ev;

    // compare levels, then optional delay of one edge per channel
    raw_a = pwm_level(eff.cnt, st_reg.buf_a, i_cfg.start_level_a);
    raw_b = pwm_level(eff.cnt, st_reg.buf_b, i_cfg.start_level_b);
    if (!st_reg.run)
    begin
      raw_a = i_cfg.start_level_a;
      raw_b = i_cfg.start_level_b;
    end
    lead_a = (raw_a == i_cfg.start_level_a);
    lead_b = (raw_b == i_cfg.start_level_b);
    da = delay_step(raw_a, st_reg.lvl_a, st_reg.dcnt_a,
      i_cfg.delay_insert_enable & (lead_a ^ i_cfg.delay_position_select),
      eff.tick, i_cfg.output_delay_value);
    db = delay_step(raw_b, st_reg.lvl_b, st_reg.dcnt_b,
      i_cfg.delay_insert_enable & (lead_b ^ ~i_cfg.delay_position_select),
      eff.tick, i_cfg.output_delay_value);
    st_next.lvl_a = da[dotmr_pkg::DLY_W];
    st_next.dcnt_a = da[dotmr_pkg::DLY_W-1:0];
    st_next.lvl_b = db[dotmr_pkg::DLY_W];
    st_next.dcnt_b = db[dotmr_pkg::DLY_W-1:0];

    // pin levels; stopped timer parks at inactive level as well
    if (!i_cfg.output_a_enable || !st_reg.run || st_next.forced)
    begin
      st_next.pin_a = i_cfg.inactive_level_a;
    end
    else
    begin
      st_next.pin_a = da[dotmr_pkg::DLY_W];
    end
    if (!i_cfg.output_b_enable || !st_reg.run || st_next.forced)
    begin
      st_next.pin_b = i_cfg.inactive_level_b;
    end
    else
    begin
      st_next.pin_b = db[dotmr_pkg::DLY_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_share = st_reg.own;
  assign o_timer_enable_bit = st_reg.run;
  assign o_counter = i_cfg.counter_share_enable ?
    i_share_group[i_cfg.share_master_select].cnt : st_reg.own.cnt;
  assign o_captured_count = st_reg.cap;
  assign o_flags = st_reg.flags;
  assign o_pwm_output_a = st_reg.pin_a;
  assign o_pwm_output_b = st_reg.pin_b;

endmodule // dotmr_timer

// File: testbench/dotmr_partner.sv
// far side: external count clock source and capture/force pin drivers
// assumes bench commands change at the falling edge of i_ref_clk
`timescale 1ns/1ps

module dotmr_partner (
  // clock
  input wire logic i_ref_clk,
  // bench commands
  input wire logic i_ext_run,
  input wire logic [3:0] i_pin_level,
  // pins toward the timer
  output logic o_ext_clk,
  output logic [3:0] o_pins,
  output int o_edges
);
  logic [1:0] ph = 2'h0;
  int edges_q = 0;
  ////////////////////////////////////////////////////////////
  // clock stands low between bursts; a started period always completes
  always @(posedge i_ref_clk)
  begin
    if (i_ext_run || ph != 2'h0)
      ph <= ph + 2'h1;
    if (ph == 2'h1)
      edges_q <= edges_q + 1;
  end
  assign o_edges = edges_q;
  assign o_ext_clk = ph[1];
  assign o_pins = i_pin_level;
endmodule // dotmr_partner

// File: testbench/dotmr_timer_asserts.sv
// checker for the timer ports: counting, flags, forcing and idle levels
// assumes one clock domain; bound into every dotmr_timer instance
`timescale 1ns/1ps

module dotmr_timer_asserts (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // watched inputs
  input wire dotmr_pkg::dotmr_cfg_s i_cfg,
  input wire logic i_counter_clear_bit,
  input wire logic [dotmr_pkg::FLAG_N-1:0] i_flag_clear,
  input wire logic [dotmr_pkg::GROUP_N-1:0] i_capture_force_input,
  // watched outputs
  input wire dotmr_pkg::dotmr_share_s o_share,
  input wire logic o_timer_enable_bit,
  input wire logic [dotmr_pkg::CNT_W-1:0] o_counter,
  input wire logic [dotmr_pkg::CNT_W-1:0] o_captured_count,
  input wire logic [dotmr_pkg::FLAG_N-1:0] o_flags,
  input wire logic o_pwm_output_a,
  input wire logic o_pwm_output_b
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // slaves show the master's count, so count checks skip them
  wire logic solo = !i_cfg.counter_share_enable;
  ////////////////////////////////////////////////////////////
  sequence s_oneshot_hit;
    i_cfg.operating_mode_field == dotmr_pkg::MODE_ONESHOT && o_share.pm && solo;
  endsequence
  sequence s_force_held;
    (i_cfg.force_enable && i_cfg.input_valid_level == 2'h1
      && i_capture_force_input[i_cfg.force_source_select]) [*4];
  endsequence
  sequence s_a_off;
    (!i_cfg.output_a_enable) [*2];
  endsequence
  ////////////////////////////////////////////////////////////
  a_flag_write_one:
    assert property (o_flags[2] && i_flag_clear[2] && !o_share.pm && solo |=> !o_flags[2])
    else $error("period flag survived a clear");
  a_flag_stays_set:
    assert property (o_flags[2] && !i_flag_clear[2] |=> o_flags[2])
    else $error("period flag dropped without a clear");
  a_match_sets_flag:
    assert property (o_share.pm && solo |=> o_flags[2])
    else $error("period match did not set its flag");
  a_count_step_wrap:
    assert property (solo && i_cfg.operating_mode_field != dotmr_pkg::MODE_B2B
      && o_timer_enable_bit && $past(o_timer_enable_bit) && !$past(i_counter_clear_bit)
      && o_counter != $past(o_counter) |-> o_counter == $past(o_counter) + 16'h0001
      || (o_counter == 16'h0000 && $past(o_counter) == i_cfg.period_value))
    else $error("counter moved by other than one step or wrap");
  a_idle_count_zero:
    assert property (solo && !o_timer_enable_bit && !$past(o_timer_enable_bit)
      |-> o_counter == 16'h0000)
    else $error("stopped counter not zero");
  a_clear_bit_zero:
    assert property (i_counter_clear_bit && solo |=> o_counter == 16'h0000)
    else $error("software clear ignored");
  a_oneshot_stop:
    assert property (s_oneshot_hit |-> ##[0:2] !o_timer_enable_bit)
    else $error("one-shot kept running");
  a_force_inactive:
    assert property (s_force_held |=> o_pwm_output_a == i_cfg.inactive_level_a
      && o_pwm_output_b == i_cfg.inactive_level_b)
    else $error("forced outputs not at inactive level");
  a_off_level_a:
    assert property (s_a_off |=> o_pwm_output_a == i_cfg.inactive_level_a)
    else $error("disabled output a not at its level");
  a_capture_only:
    assert property (o_captured_count != $past(o_captured_count)
      |-> $past(i_cfg.operating_mode_field) == dotmr_pkg::MODE_CAPTURE)
    else $error("capture value changed outside capture mode");
  a_bottom_b2b:
    assert property ($rose(o_flags[3])
      |-> $past(i_cfg.operating_mode_field) == dotmr_pkg::MODE_B2B)
    else $error("bottom flag outside back-to-back mode");
endmodule // dotmr_timer_asserts

bind dotmr_timer dotmr_timer_asserts u_asserts (
  .i_ref_clk, .i_rst_n, .i_cfg, .i_counter_clear_bit, .i_flag_clear,
  .i_capture_force_input, .o_share, .o_timer_enable_bit, .o_counter,
  .o_captured_count, .o_flags, .o_pwm_output_a, .o_pwm_output_b
);

// File: testbench/tb_dual_output_updown_pwm_timer.sv
// self-checking bench: counter and pwm model, flags, capture, force, sharing
// assumes dotmr_pkg, dotmr_timer, the partner and the bound checker are compiled
`timescale 1ns/1ps

module tb_dual_output_updown_pwm_timer;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  dotmr_pkg::dotmr_cfg_s cfg = '0;
  logic en = 1'b0;
  logic clr = 1'b0;
  logic [5:0] fclr = 6'h00;
  dotmr_pkg::dotmr_share_s [3:0] grp = '0;
  logic ext_run = 1'b0;
  logic [3:0] pin_lvl = 4'h0;
  logic ext_clk;
  logic [3:0] pins;
  int edges;
  logic run;
  logic [15:0] cnt;
  logic [15:0] cap;
  logic [5:0] flags;
  logic pa;
  logic pb;
  int mismatches = 0;
  int tests_run = 0;
  logic [7:0] seed = 8'h42;
  int p;
  int n;
  int k;

  always #20 i_ref_clk = ~i_ref_clk;

  dotmr_timer dut (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cfg(cfg),
    .i_timer_enable_bit(en), .i_counter_clear_bit(clr), .i_flag_clear(fclr),
    .i_external_count_clock(ext_clk), .i_capture_force_input(pins),
    .i_share_group(grp), .o_share(), .o_timer_enable_bit(run), .o_counter(cnt),
    .o_captured_count(cap), .o_flags(flags), .o_pwm_output_a(pa), .o_pwm_output_b(pb)
  );
  dotmr_partner u_partner (
    .i_ref_clk(i_ref_clk), .i_ext_run(ext_run), .i_pin_level(pin_lvl),
    .o_ext_clk(ext_clk), .o_pins(pins), .o_edges(edges)
  );
  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic final_report();
    if (mismatches == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge i_ref_clk);
  endtask
  task automatic wait_cnt(input logic [15:0] v);
    k = 0;
    while (cnt !== v && k < 200)
    begin
      cyc(1);
      k++;
    end
    if (cnt !== v)
    begin
      mismatches++;
      final_report();
    end
  endtask
  // settings change only while stopped
  task automatic start(input dotmr_pkg::dotmr_mode_e m, input int pv, input int nv);
    en = 1'b0;
    cyc(1);
    cfg.operating_mode_field = m;
    cfg.prescaler_value = pv[11:0];
    cfg.period_value = nv[15:0];
    cyc(2);
    en = 1'b1;
  endtask
  // model resyncs when the counter first reads one; pin lags counter a cycle
  task automatic track(input int len, input logic b2b);
    int m;
    int q;
    logic up;
    logic la;
    logic lb;
    m = 1;
    q = 0;
    up = 1'b1;
    wait_cnt(16'h0001);
    repeat (len)
    begin
      la = cfg.start_level_a ^ (m >= cfg.duty_a_value);
      lb = cfg.start_level_b ^ (m >= cfg.duty_b_value);
      cyc(1);
      q++;
      if (q == p + 1)
      begin
        q = 0;
        if (b2b && m == n) up = 1'b0;
        if (b2b && m == 0) up = 1'b1;
        m = (!b2b && m == n) ? 0 : (up ? m + 1 : m - 1);
      end
      chk(cnt === m[15:0], "counter step");
      chk(pa === la && pb === lb, "pwm level");
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    seed = lfsr(seed);
    cfg.output_a_enable = 1'b1;
    cfg.output_b_enable = 1'b1;
    {cfg.start_level_a, cfg.start_level_b, cfg.inactive_level_a} = seed[2:0];
    cfg.inactive_level_b = ~seed[2];
    cfg.force_source_select = seed[6:5];
    cyc(3);
    chk({run, cnt, cap, flags, pa, pb} === '0, "reset values");
    i_rst_n = 1'b1;
    cyc(3);
    chk(pa === cfg.inactive_level_a && pb === cfg.inactive_level_b, "idle pins");
    for (int i = 0; i < 2; i++)
    begin
      seed = lfsr(seed);
      p = seed[1:0];
      n = 6 + seed[4:2];
      cfg.duty_a_value = 16'(2 + seed[1:0]);
      cfg.duty_b_value = 16'(n - 1);
      start(i ? dotmr_pkg::MODE_B2B : dotmr_pkg::MODE_INTERVAL, p, n);
      track(120, i[0]);
      en = 1'b0;
      cyc(3);
      chk(flags[3:0] === {i[0], 3'h7}, "match flags");
      fclr = 6'h0f;
      cyc(1);
      fclr = 6'h00;
      chk(flags[3:0] === 4'h0, "flag clear");
    end
    cfg.output_a_enable = 1'b0;
    start(dotmr_pkg::MODE_INTERVAL, 0, 200);
    cyc(3);
    chk(pa === cfg.inactive_level_a && pb === cfg.start_level_b, "disabled pin a");
    cyc(17);
    clr = 1'b1;
    cyc(2);
    chk(cnt === 16'h0000 && run === 1'b1, "software clear");
    clr = 1'b0;
    cfg.output_a_enable = 1'b1;
    start(dotmr_pkg::MODE_ONESHOT, 0, 5);
    cyc(3);
    k = 3;
    while (run === 1'b1 && k < 40)
    begin
      cyc(1);
      k++;
    end
    cyc(1);
    chk(k >= 5 && k < 12 && flags[2] === 1'b1, "one-shot stop");
    if (k == 40)
      final_report();
    cyc(10);
    chk(run === 1'b0 && cnt === 16'h0000, "one-shot stays stopped");
    cfg.input_valid_level = dotmr_pkg::INP_HIGH_RISE;
    start(dotmr_pkg::MODE_CAPTURE, 15, 255);
    wait_cnt(16'h0003);
    pin_lvl[cfg.force_source_select] = 1'b1;
    cyc(6);
    chk(cap === 16'h0003 && flags[4] === 1'b1, "capture value");
    pin_lvl = 4'h0;
    cyc(2);
    cfg.force_enable = 1'b1;
    start(dotmr_pkg::MODE_INTERVAL, 0, 20);
    cyc(4);
    pin_lvl[cfg.force_source_select] = 1'b1;
    cyc(5);
    chk(pa === cfg.inactive_level_a && pb === cfg.inactive_level_b, "forced pins");
    chk(flags[5] === 1'b1, "force flag");
    pin_lvl = 4'h0;
    en = 1'b0;
    cyc(1);
    cfg.force_enable = 1'b0;
    cfg.clock_source_select = 1'b1;
    start(dotmr_pkg::MODE_INTERVAL, 0, 65535);
    cyc(4);
    k = edges;
    ext_run = 1'b1;
    cyc(40);
    ext_run = 1'b0;
    cyc(8);
    chk(cnt === 16'(edges - k), "external clock count");
    en = 1'b0;
    cyc(1);
    // bench plays the master with fixed random counts and tick held high
    cfg.clock_source_select = 1'b0;
    cfg.counter_share_enable = 1'b1;
    cfg.share_master_select = 2'h0;
    for (int j = 0; j < 4; j++)
    begin
      seed = lfsr(seed);
      grp[j].cnt = {seed, ~seed};
      grp[j].tick = 1'b1;
    end
    start(dotmr_pkg::MODE_INTERVAL, 0, 65535);
    cyc(4);
    chk(cnt === grp[0].cnt, "shared counter");
    final_report();
  end
endmodule // tb_dual_output_updown_pwm_timer
